// ---- verilog/exu_core.sv ----
// Execution unit for memory-operand 8-bit ops and 16-bit pair arithmetic.
// Assumes an APB3 master; software loads operands and the memory byte.
// Functional notes
// - XOR immediate: result, flags, 2 M/7 T
// - SBC memory: subtract with borrow, flags set
// - AND memory: H set, C and N cleared
// - OR memory: H, N, C cleared, parity
// - XOR memory: H, N, C cleared, parity
// - CP memory: flags only, accumulator kept
// - Prefix bit 5 selects index register; 5/19
// - INC memory: plus one, carry kept, timing
// - DEC memory: minus one, N set, carry kept
// - ADD16: S Z PV kept, H11, C15
// - ADC16: S Z, 16-bit overflow, carry out
// - SBC16: H12 borrow, overflow, N, 4/15
// - INC16: no flags; 1 M or 2/10
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module exu_core (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [exu_pkg::AW-1:0] paddr,
  input wire logic [exu_pkg::DW-1:0] pwdata,
  output logic pready,
  output logic [exu_pkg::DW-1:0] prdata,
  output logic pslverr
);
  import exu_pkg::*;

  typedef struct packed {
    exu_st_e st;
    logic done;
    logic bad;
    logic [3:0] mcyc;
    logic [4:0] tst;
    logic [7:0] acc;
    logic [7:0] flg;
    logic [15:0] ptr;
    logic [15:0] ix0;
    logic [15:0] ix1;
    logic [15:0] sp;
    logic [15:0] pr0;
    logic [15:0] pr1;
    logic [7:0] mem;
    logic [15:0] ea;
    logic [7:0] ob0;
    logic [7:0] ob1;
    logic [7:0] ob2;
    logic pready;
    logic pslverr;
    logic [DW-1:0] prdata;
  } exu_state_s;

  exu_state_s r;
  exu_state_s n;
  logic fire;
  logic wr_ok;
  logic hit;
  logic [DW-1:0] rd_word;
  logic pfx;
  logic ed;
  logic [7:0] opc;
  logic [1:0] fld;
  logic [15:0] idx;
  logic [15:0] ea;
  logic [15:0] dst16;
  logic [15:0] src16;
  logic [15:0] inc_v;
  logic is_mem;
  logic is_imm;
  logic is_incm;
  logic is_decm;
  logic is_add16;
  logic is_inc16;
  logic is_adc16;
  logic is_sbc16;
  logic cw;
  logic v16;
  logic [16:0] s16;
  logic [12:0] h16;
  logic [7:0] fw;
  logic [7:0] a8;
  logic [7:0] b8;
  logic [2:0] aop;
  logic [7:0] res8;
  logic [7:0] fl8;

  // Instruction decode from the loaded opcode bytes
  assign fire = (r.st == EXU_EXEC);
  assign pfx = (r.ob0 == OP_PFX_IX0) || (r.ob0 == OP_PFX_IX1);
  assign ed = (r.ob0 == OP_PFX_ED);
  assign opc = (pfx || ed) ? r.ob1 : r.ob0;
  assign fld = opc[5:4];
  assign is_mem = !ed && opc[7:6] == GRP_ALU && opc[2:0] == SRC_MEM;
  assign is_imm = !pfx && !ed && opc[7:6] == GRP_IMM && opc[2:0] == SRC_MEM;
  assign is_incm = !ed && opc == OP_INC_M;
  assign is_decm = !ed && opc == OP_DEC_M;
  assign is_add16 = !ed && opc[7:6] == GRP_LOW && opc[3:0] == LO_ADD16;
  assign is_inc16 = !ed && opc[7:6] == GRP_LOW && opc[3:0] == LO_INC16 && (!pfx || opc == OP_INC_IDX);
  assign is_adc16 = ed && opc[7:6] == GRP_ED16 && opc[3:0] == LO_ADC16;
  assign is_sbc16 = ed && opc[7:6] == GRP_ED16 && opc[3:0] == LO_SBC16;

  // Operand addressing; the displacement is signed so negative offsets wrap
  assign idx = r.ob0[PFX_SEL_BIT] ? r.ix1 : r.ix0;
  assign ea = pfx ? 16'(idx + {{8{r.ob2[7]}}, r.ob2}) : r.ptr;
  assign dst16 = pfx ? idx : r.ptr;
  assign src16 = (fld == PF_P0) ? r.pr0 : (fld == PF_P1) ? r.pr1 : (fld == PF_PTR) ? dst16 : r.sp;
  assign inc_v = 16'(src16 + 16'h0001);

  // ALU operand steering; INC and DEC reuse add and subtract by one
  assign a8 = (is_incm || is_decm) ? r.mem : r.acc;
  assign b8 = is_imm ? r.ob1 : (is_incm || is_decm) ? 8'h01 : r.mem;
  assign aop = is_incm ? ALU_ADD : is_decm ? ALU_SUB : opc[5:3];

  exu_alu8 u_alu (
    .a(a8),
    .b(b8),
    .cin(r.flg[FL_C]),
    .op(aop),
    .res(res8),
    .flags(fl8)
  );

  // Wide arithmetic; a 17-bit sum gives carry or borrow out of bit 15
  assign cw = (is_adc16 || is_sbc16) && r.flg[FL_C];
  assign s16 = is_sbc16 ? 17'({1'b0, dst16} - {1'b0, src16} - 17'(cw)) :
               17'({1'b0, dst16} + {1'b0, src16} + 17'(cw));
  assign h16 = is_sbc16 ? 13'({1'b0, dst16[11:0]} - {1'b0, src16[11:0]} - 13'(cw)) :
               13'({1'b0, dst16[11:0]} + {1'b0, src16[11:0]} + 13'(cw));
  assign v16 = is_sbc16 ? (dst16[15] != src16[15]) && (s16[15] != dst16[15]) :
               (dst16[15] == src16[15]) && (s16[15] != dst16[15]);
  // Flag byte in S Z - H - PV N C order
  assign fw = {s16[15], s16[15:0] == 16'h0000, 1'b0, h16[12], 1'b0, v16, is_sbc16, s16[16]};

  // APB read decode
  always_comb begin
    hit = 1'b1;
    rd_word = '0;
    if (paddr == REG_CTRL) begin
      rd_word = '0;
    end else if (paddr == REG_STAT) begin
      rd_word = {11'h000, r.tst, 4'h0, r.mcyc, 5'h00, r.bad, r.done, fire};
    end else if (paddr == REG_OPC) begin
      rd_word = {8'h00, r.ob2, r.ob1, r.ob0};
    end else if (paddr == REG_ACC) begin
      rd_word = {24'h000000, r.acc};
    end else if (paddr == REG_FLG) begin
      rd_word = {24'h000000, r.flg};
    end else if (paddr == REG_PTR) begin
      rd_word = {16'h0000, r.ptr};
    end else if (paddr == REG_IX0) begin
      rd_word = {16'h0000, r.ix0};
    end else if (paddr == REG_IX1) begin
      rd_word = {16'h0000, r.ix1};
    end else if (paddr == REG_SP) begin
      rd_word = {16'h0000, r.sp};
    end else if (paddr == REG_PR0) begin
      rd_word = {16'h0000, r.pr0};
    end else if (paddr == REG_PR1) begin
      rd_word = {16'h0000, r.pr1};
    end else if (paddr == REG_MEM) begin
      rd_word = {24'h000000, r.mem};
    end else if (paddr == REG_ADDR) begin
      rd_word = {16'h0000, r.ea};
    end else begin
      hit = 1'b0;
    end
  end

  // Writes land only on the completing edge of the access phase
  assign wr_ok = psel && penable && r.pready && pwrite;

  // Next state: bus slave first, then execution, which wins any overlap
  always_comb begin
    n = r;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    if (psel && penable && !r.pready) begin
      n.pready = 1'b1;
      n.prdata = rd_word;
      n.pslverr = !hit;
    end
    if (wr_ok) begin
      if (paddr == REG_OPC) begin
        n.ob0 = pwdata[7:0];
        n.ob1 = pwdata[15:8];
        n.ob2 = pwdata[23:16];
      end else if (paddr == REG_ACC) begin
        n.acc = pwdata[7:0];
      end else if (paddr == REG_FLG) begin
        n.flg = pwdata[7:0];
      end else if (paddr == REG_PTR) begin
        n.ptr = pwdata[15:0];
      end else if (paddr == REG_IX0) begin
        n.ix0 = pwdata[15:0];
      end else if (paddr == REG_IX1) begin
        n.ix1 = pwdata[15:0];
      end else if (paddr == REG_SP) begin
        n.sp = pwdata[15:0];
      end else if (paddr == REG_PR0) begin
        n.pr0 = pwdata[15:0];
      end else if (paddr == REG_PR1) begin
        n.pr1 = pwdata[15:0];
      end else if (paddr == REG_MEM) begin
        n.mem = pwdata[7:0];
      end
    end
    case (r.st)
      EXU_IDLE: begin
        if (wr_ok && paddr == REG_CTRL && pwdata[CTRL_GO]) begin
          n.st = EXU_EXEC;
          n.done = 1'b0;
        end
      end
      EXU_EXEC: begin
        n.st = EXU_IDLE;
        n.done = 1'b1;
        n.bad = 1'b0;
        n.ea = ea;
        if (is_imm || is_mem) begin
          // Compare only sets flags; other ops load the accumulator
          if (aop != ALU_CP) begin
            n.acc = res8;
          end
          n.flg = (fl8 & FM_ALL) | (r.flg & ~FM_ALL);
          n.mcyc = pfx ? MC_ALU_IDX : MC_ALU_PTR;
          n.tst = pfx ? TS_ALU_IDX : TS_ALU_PTR;
        end else if (is_incm || is_decm) begin
          n.mem = res8;
          n.flg = (fl8 & FM_NOC) | (r.flg & ~FM_NOC);
          n.mcyc = pfx ? MC_INCD_IDX : MC_INCD_PTR;
          n.tst = pfx ? TS_INCD_IDX : TS_INCD_PTR;
        end else if (is_add16) begin
          if (!pfx) begin
            n.ptr = s16[15:0];
          end else if (r.ob0[PFX_SEL_BIT]) begin
            n.ix1 = s16[15:0];
          end else begin
            n.ix0 = s16[15:0];
          end
          n.flg = (fw & FM_ADD16) | (r.flg & ~FM_ADD16);
          n.mcyc = pfx ? MC_WIDE : MC_ADD16_PTR;
          n.tst = pfx ? TS_WIDE : TS_ADD16_PTR;
        end else if (is_adc16 || is_sbc16) begin
          n.ptr = s16[15:0];
          n.flg = (fw & FM_ALL) | (r.flg & ~FM_ALL);
          n.mcyc = MC_WIDE;
          n.tst = TS_WIDE;
        end else if (is_inc16) begin
          if (pfx && r.ob0[PFX_SEL_BIT]) begin
            n.ix1 = inc_v;
          end else if (pfx) begin
            n.ix0 = inc_v;
          end else if (fld == PF_P0) begin
            n.pr0 = inc_v;
          end else if (fld == PF_P1) begin
            n.pr1 = inc_v;
          end else if (fld == PF_PTR) begin
            n.ptr = inc_v;
          end else begin
            n.sp = inc_v;
          end
          n.mcyc = pfx ? MC_INC16_IDX : MC_INC16;
          n.tst = pfx ? TS_INC16_IDX : TS_INC16;
        end else begin
          // Unsupported opcode: registers and flags kept except the address register, which takes the decoded address; error flag set, cycle and state counts cleared
          n.bad = 1'b1;
          n.mcyc = 4'h0;
          n.tst = 5'h00;
        end
      end
      default: n.st = EXU_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign pready = r.pready;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_xor_imm: assert property (fire && is_imm && opc == OP_XOR_IMM |=>
    r.acc == ($past(r.acc) ^ $past(r.ob1)) && !r.flg[FL_H] && !r.flg[FL_C] && !r.flg[FL_N]
    && r.mcyc == MC_ALU_PTR && r.tst == TS_ALU_PTR) else $error("xor immediate wrong");
  a_sbc_mem: assert property (fire && is_mem && aop == ALU_SBC |=>
    r.acc == 8'($past(r.acc) - $past(r.mem) - $past(r.flg[FL_C])) && r.flg[FL_N])
    else $error("sbc memory wrong");
  a_and_mem: assert property (fire && is_mem && aop == ALU_AND |=>
    r.acc == ($past(r.acc) & $past(r.mem)) && r.flg[FL_H] && !r.flg[FL_C] && r.flg[FL_PV] == ~^r.acc)
    else $error("and memory wrong");
  a_or_mem: assert property (fire && is_mem && aop == ALU_OR |=>
    r.acc == ($past(r.acc) | $past(r.mem)) && !r.flg[FL_H] && !r.flg[FL_N] && !r.flg[FL_C])
    else $error("or memory wrong");
  a_xor_mem: assert property (fire && is_mem && aop == ALU_XOR |=>
    r.acc == ($past(r.acc) ^ $past(r.mem)) && r.flg[FL_PV] == ~^r.acc && !r.flg[FL_H])
    else $error("xor memory wrong");
  a_cp_keep: assert property (fire && is_mem && aop == ALU_CP |=>
    r.acc == $past(r.acc) && r.flg[FL_N] && r.flg[FL_C] == ($past(r.acc) < $past(r.mem)))
    else $error("compare wrong");
  a_idx_sel: assert property (fire && is_mem && pfx && r.ob2 == 8'h00 |=>
    r.ea == ($past(r.ob0[PFX_SEL_BIT]) ? $past(r.ix1) : $past(r.ix0))
    && r.mcyc == MC_ALU_IDX && r.tst == TS_ALU_IDX) else $error("index select wrong");
  a_inc_mem: assert property (fire && is_incm |=>
    r.mem == 8'($past(r.mem) + 8'h01) && r.flg[FL_C] == $past(r.flg[FL_C])
    && r.flg[FL_PV] == ($past(r.mem) == MEM_MAXPOS) && !r.flg[FL_N]
    && r.tst == ($past(pfx) ? TS_INCD_IDX : TS_INCD_PTR)) else $error("inc memory wrong");
  a_dec_mem: assert property (fire && is_decm |=>
    r.mem == 8'($past(r.mem) - 8'h01) && r.flg[FL_C] == $past(r.flg[FL_C])
    && r.flg[FL_PV] == ($past(r.mem) == MEM_MAXNEG) && r.flg[FL_N]) else $error("dec memory wrong");
  a_add16_keep: assert property (fire && is_add16 |=>
    (r.flg & FM_SZP) == ($past(r.flg) & FM_SZP) && !r.flg[FL_N]) else $error("add16 flags wrong");
  a_adc16_sum: assert property (fire && is_adc16 |=>
    {r.flg[FL_C], r.ptr} == 17'({1'b0, $past(r.ptr)} + {1'b0, $past(src16)} + 17'($past(r.flg[FL_C])))
    && r.flg[FL_Z] == (r.ptr == 16'h0000)) else $error("adc16 wrong");
  a_sbc16_diff: assert property (fire && is_sbc16 |=>
    {r.flg[FL_C], r.ptr} == 17'({1'b0, $past(r.ptr)} - {1'b0, $past(src16)} - 17'($past(r.flg[FL_C])))
    && r.flg[FL_N] && r.mcyc == MC_WIDE && r.tst == TS_WIDE) else $error("sbc16 wrong");
  a_inc16_flags: assert property (fire && is_inc16 |=>
    r.flg == $past(r.flg) && r.mcyc == ($past(pfx) ? MC_INC16_IDX : MC_INC16)) else $error("inc16 wrong");
  a_disp_sext: assert property (fire && pfx && (is_mem || is_incm || is_decm) |=>
    r.ea == 16'($past(idx) + {{8{$past(r.ob2[7])}}, $past(r.ob2)})) else $error("indexed address wrong");
endmodule

// ---- verilog/exu_pkg.sv ----
// Constants shared by the execution unit core and its 8-bit ALU.
// Assumes a 32-bit APB master and operands loaded by software.
package exu_pkg;
  localparam int AW = 8;
  localparam int DW = 32;
  // Register byte offsets
  localparam logic [AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AW-1:0] REG_STAT = 8'h04;
  localparam logic [AW-1:0] REG_OPC = 8'h08;
  localparam logic [AW-1:0] REG_ACC = 8'h0C;
  localparam logic [AW-1:0] REG_FLG = 8'h10;
  localparam logic [AW-1:0] REG_PTR = 8'h14;
  localparam logic [AW-1:0] REG_IX0 = 8'h18;
  localparam logic [AW-1:0] REG_IX1 = 8'h1C;
  localparam logic [AW-1:0] REG_SP = 8'h20;
  localparam logic [AW-1:0] REG_PR0 = 8'h24;
  localparam logic [AW-1:0] REG_PR1 = 8'h28;
  localparam logic [AW-1:0] REG_MEM = 8'h2C;
  localparam logic [AW-1:0] REG_ADDR = 8'h30;
  localparam int CTRL_GO = 0;
  // Opcode bytes and opcode patterns
  localparam logic [7:0] OP_PFX_IX0 = 8'hDD;
  localparam logic [7:0] OP_PFX_IX1 = 8'hFD;
  localparam logic [7:0] OP_PFX_ED = 8'hED;
  localparam logic [7:0] OP_XOR_IMM = 8'hEE;
  localparam logic [7:0] OP_INC_M = 8'h34;
  localparam logic [7:0] OP_DEC_M = 8'h35;
  localparam logic [7:0] OP_INC_IDX = 8'h23;
  localparam int PFX_SEL_BIT = 5;
  localparam logic [1:0] GRP_LOW = 2'h0;
  localparam logic [1:0] GRP_ED16 = 2'h1;
  localparam logic [1:0] GRP_ALU = 2'h2;
  localparam logic [1:0] GRP_IMM = 2'h3;
  localparam logic [2:0] SRC_MEM = 3'h6;
  localparam logic [3:0] LO_ADD16 = 4'h9;
  localparam logic [3:0] LO_INC16 = 4'h3;
  localparam logic [3:0] LO_ADC16 = 4'hA;
  localparam logic [3:0] LO_SBC16 = 4'h2;
  // Pair operand field codes
  localparam logic [1:0] PF_P0 = 2'h0;
  localparam logic [1:0] PF_P1 = 2'h1;
  localparam logic [1:0] PF_PTR = 2'h2;
  // ALU operation codes, equal to opcode bits 5:3
  localparam logic [2:0] ALU_ADD = 3'h0;
  localparam logic [2:0] ALU_ADC = 3'h1;
  localparam logic [2:0] ALU_SUB = 3'h2;
  localparam logic [2:0] ALU_SBC = 3'h3;
  localparam logic [2:0] ALU_AND = 3'h4;
  localparam logic [2:0] ALU_XOR = 3'h5;
  localparam logic [2:0] ALU_OR = 3'h6;
  localparam logic [2:0] ALU_CP = 3'h7;
  // Flag bit positions and update masks
  localparam int FL_S = 7;
  localparam int FL_Z = 6;
  localparam int FL_H = 4;
  localparam int FL_PV = 2;
  localparam int FL_N = 1;
  localparam int FL_C = 0;
  localparam logic [7:0] FM_ALL = 8'hD7;
  localparam logic [7:0] FM_NOC = 8'hD6;
  localparam logic [7:0] FM_ADD16 = 8'h13;
  localparam logic [7:0] FM_SZP = 8'hC4;
  localparam logic [7:0] MEM_MAXPOS = 8'h7F;
  localparam logic [7:0] MEM_MAXNEG = 8'h80;
  // Machine cycles and clock states per instruction form
  localparam logic [3:0] MC_ALU_PTR = 4'h2;
  localparam logic [4:0] TS_ALU_PTR = 5'h07;
  localparam logic [3:0] MC_ALU_IDX = 4'h5;
  localparam logic [4:0] TS_ALU_IDX = 5'h13;
  localparam logic [3:0] MC_INCD_PTR = 4'h3;
  localparam logic [4:0] TS_INCD_PTR = 5'h0B;
  localparam logic [3:0] MC_INCD_IDX = 4'h6;
  localparam logic [4:0] TS_INCD_IDX = 5'h17;
  localparam logic [3:0] MC_ADD16_PTR = 4'h3;
  localparam logic [4:0] TS_ADD16_PTR = 5'h0B;
  localparam logic [3:0] MC_WIDE = 4'h4;
  localparam logic [4:0] TS_WIDE = 5'h0F;
  localparam logic [3:0] MC_INC16 = 4'h1;
  localparam logic [4:0] TS_INC16 = 5'h04;
  localparam logic [3:0] MC_INC16_IDX = 4'h2;
  localparam logic [4:0] TS_INC16_IDX = 5'h0A;
  typedef enum logic {EXU_IDLE, EXU_EXEC} exu_st_e;
endpackage

// ---- verilog/exu_alu8.sv ----
// 8-bit accumulator ALU with flag generation.
// Assumes the caller merges flags and holds the carry where needed.
`timescale 1ns/1ps
module exu_alu8 (
  // Operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  input wire logic [2:0] op,
  // Results
  output logic [7:0] res,
  output logic [7:0] flags
);
  import exu_pkg::*;
  logic c;
  logic sub;
  logic arith;
  logic v;
  logic [8:0] s9;
  logic [4:0] h5;

  // Arithmetic and logic result with all flags
  always_comb begin
    c = (op == ALU_ADC || op == ALU_SBC) && cin;
    sub = (op == ALU_SUB) || (op == ALU_SBC) || (op == ALU_CP);
    arith = !op[2] || (op == ALU_CP);
    if (sub) begin
      s9 = 9'({1'b0, a} - {1'b0, b} - 9'(c));
      h5 = 5'({1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(c));
      v = (a[7] != b[7]) && (s9[7] != a[7]);
    end else begin
      s9 = 9'({1'b0, a} + {1'b0, b} + 9'(c));
      h5 = 5'({1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(c));
      v = (a[7] == b[7]) && (s9[7] != a[7]);
    end
    if (op == ALU_AND) begin
      res = a & b;
    end else if (op == ALU_XOR) begin
      res = a ^ b;
    end else if (op == ALU_OR) begin
      res = a | b;
    end else begin
      res = s9[7:0];
    end
    flags = 8'h00;
    flags[FL_S] = res[7];
    flags[FL_Z] = (res == 8'h00);
    flags[FL_H] = arith ? h5[4] : (op == ALU_AND);
    flags[FL_PV] = arith ? v : ~^res;
    flags[FL_N] = sub;
    flags[FL_C] = arith && s9[8];
  end
endmodule

// ---- sim/exu_apb_host.sv ----
// APB master model on the host side of the execution unit.
// Assumes one clock; requests change only just after a rising edge.
`timescale 1ns/1ps
module exu_apb_host (
  // Clock
  input wire logic core_clk,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [exu_pkg::AW-1:0] paddr,
  output logic [exu_pkg::DW-1:0] pwdata,
  // Answer
  input wire logic pready,
  input wire logic [exu_pkg::DW-1:0] prdata,
  input wire logic pslverr
);
  import exu_pkg::*;
  logic to_hit;
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    to_hit = 1'b0;
  end
  // One transfer; the answer is taken at the edge that samples pready high
  task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d,
                      output logic [DW-1:0] rd, output logic er);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    er = pslverr;
    to_hit = (pready !== 1'b1);
    // Released lines carry inverted values so stale data never looks valid
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ---- sim/exu_core_tb_top.sv ----
// Self-checking bench for the execution unit, driven over APB.
// Assumes the host model for bus cycles and a result ready before STAT is read.
`timescale 1ns/1ps
module exu_core_tb_top;
  import exu_pkg::*;
`define CHK(g, x) begin check_count++; if ((g) !== (x)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (x)); end end
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, e, idx;
  logic [AW-1:0] paddr;
  logic [DW-1:0] pwdata, prdata, q, r, seed;
  logic [15:0] hl, x0, x1, p, a8;
  logic [7:0] ac, mm, d, fl;
  logic [23:0] w;
  logic [2:0] op;
  logic [1:0] k;
  int i, bad_count, check_count;
  logic [2:0] ops [8] = '{ALU_SBC, ALU_AND, ALU_OR, ALU_XOR, ALU_CP, ALU_ADD, ALU_ADC, ALU_SUB};
  logic [7:0] cm [4] = '{8'h7F, 8'h80, 8'hFF, 8'h00};
  exu_core i_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  exu_apb_host i_host (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Xorshift source, repeatable from its fixed start
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected 8-bit result and flags; CP keeps the accumulator
  function automatic logic [15:0] alu8(input logic [2:0] o, input logic [7:0] a, b, input logic c);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] y;
    logic cc, sb;
    sb = (o == ALU_SUB) || (o == ALU_SBC) || (o == ALU_CP);
    cc = (o == ALU_SBC || o == ALU_ADC) & c;
    s = sb ? a - b - cc : a + b + cc;
    h = sb ? a[3:0] - b[3:0] - cc : a[3:0] + b[3:0] + cc;
    y = (o == ALU_AND) ? a & b : (o == ALU_OR) ? a | b : (o == ALU_XOR) ? a ^ b : s[7:0];
    if (!o[2] || o == ALU_CP)
      return {(o == ALU_CP) ? a : y, y[7], y == 0, 1'b0, h[4], 1'b0,
              (sb ? a[7] ^ b[7] : ~(a[7] ^ b[7])) & (y[7] ^ a[7]), sb, s[8]};
    return {y, y[7], y == 0, 1'b0, o == ALU_AND, 1'b0, ~^y, 2'b00};
  endfunction
  // Expected memory byte and flags for increment or decrement
  function automatic logic [15:0] idm(input logic dn, input logic [7:0] m, input logic c);
    logic [7:0] y;
    y = dn ? m - 8'h01 : m + 8'h01;
    return {y, y[7], y == 0, 1'b0, dn ? m[3:0] == 4'h0 : m[3:0] == 4'hF, 1'b0,
            m == (dn ? 8'h80 : 8'h7F), dn, c};
  endfunction
  // Expected pair result and flags: 0 add, 1 add with carry, 2 subtract with carry
  function automatic logic [23:0] w16(input logic [1:0] t, input logic [15:0] a, b, input logic [7:0] f);
    logic [16:0] s;
    logic [12:0] h;
    logic c, v;
    c = (t != 2'd0) & f[0];
    s = (t == 2'd2) ? a - b - c : a + b + c;
    h = (t == 2'd2) ? a[11:0] - b[11:0] - c : a[11:0] + b[11:0] + c;
    v = ((t == 2'd2) ? a[15] ^ b[15] : ~(a[15] ^ b[15])) & (s[15] ^ a[15]);
    if (t == 2'd0)
      return {s[15:0], f[7:6], 1'b0, h[12], 1'b0, f[2], 1'b0, s[16]};
    return {s[15:0], s[15], s[15:0] == 0, 1'b0, h[12], 1'b0, v, t == 2'd2, s[16]};
  endfunction
  // Bus access; a hung transfer ends the run
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dd);
    i_host.xfer(wr, a, dd, q, e);
    if (i_host.to_hit !== 1'b0) begin
      bad_count++;
      wrap_up();
    end
  endtask
  task automatic go(input logic [23:0] o);
    bus(1'b1, REG_OPC, {8'h00, o});
    bus(1'b1, REG_CTRL, 32'h1);
  endtask
  task automatic stat(input logic [3:0] m, input logic [4:0] t);
    bus(1'b0, REG_STAT, 32'h0);
    `CHK(q, {11'h000, t, 4'h0, m, 8'h02})
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    seed = 32'd92;
    bad_count = 0;
    check_count = 0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    bus(1'b0, REG_ACC, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b0, 8'h3C, 32'h0);
    `CHK({e, q}, 33'h1_0000_0000)
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    `CHK(e, 1'b1)
    // Memory-operand ops, all eight ALU codes, pointer and indexed, then immediate XOR
    for (i = 0; i < 40; i++) begin
      r = rnd();
      hl = r[15:0];
      x0 = r[31:16];
      r = rnd();
      x1 = r[15:0];
      bus(1'b1, REG_PTR, {16'h0, hl});
      bus(1'b1, REG_IX0, {16'h0, x0});
      bus(1'b1, REG_IX1, {16'h0, x1});
      r = rnd();
      op = ops[i % 8];
      // Some indexed cases use a zero displacement so the bare index register shows
      idx = r[8] | (i % 8 == 1);
      d = (i % 8 == 1) ? 8'h00 : r[23:16];
      ac = r[7:0];
      mm = (i < 5) ? ac : r[15:8];
      bus(1'b1, REG_ACC, {24'h0, ac});
      bus(1'b1, REG_MEM, {24'h0, mm});
      bus(1'b1, REG_FLG, {31'h0, r[10]});
      go(idx ? {d, 2'b10, op, 3'b110, r[9] ? OP_PFX_IX1 : OP_PFX_IX0} : {16'h0, 2'b10, op, 3'b110});
      a8 = alu8(op, ac, mm, r[10]);
      bus(1'b0, REG_ACC, 32'h0);
      `CHK(q, {24'h0, a8[15:8]})
      bus(1'b0, REG_FLG, 32'h0);
      `CHK(q, {24'h0, a8[7:0]})
      stat(idx ? 4'h5 : 4'h2, idx ? 5'h13 : 5'h07);
      bus(1'b0, REG_ADDR, 32'h0);
      `CHK(q, {16'h0, idx ? (r[9] ? x1 : x0) + {{8{d[7]}}, d} : hl})
      bus(1'b1, REG_ACC, {24'h0, ac});
      go({8'h00, mm, OP_XOR_IMM});
      a8 = alu8(ALU_XOR, ac, mm, 1'b0);
      bus(1'b0, REG_ACC, 32'h0);
      `CHK(q, {24'h0, a8[15:8]})
      bus(1'b0, REG_FLG, 32'h0);
      `CHK(q, {24'h0, a8[7:0]})
      stat(4'h2, 5'h07);
    end
    // Memory increment and decrement, boundary bytes first
    for (i = 0; i < 12; i++) begin
      r = rnd();
      idx = i[1];
      d = r[23:16];
      mm = (i < 4) ? cm[i] : r[7:0];
      fl = r[15:8] & 8'hD7;
      bus(1'b1, REG_MEM, {24'h0, mm});
      bus(1'b1, REG_FLG, {24'h0, fl});
      go(idx ? {d, 7'b0011010, i[0], r[9] ? OP_PFX_IX1 : OP_PFX_IX0} : {16'h0, 7'b0011010, i[0]});
      a8 = idm(i[0], mm, fl[0]);
      bus(1'b0, REG_MEM, 32'h0);
      `CHK(q, {24'h0, a8[15:8]})
      bus(1'b0, REG_FLG, 32'h0);
      `CHK(q, {24'h0, a8[7:0]})
      stat(idx ? 4'h6 : 4'h3, idx ? 5'h17 : 5'h0B);
    end
    // Pair add, add with carry and subtract with carry into the pointer pair
    for (i = 0; i < 9; i++) begin
      r = rnd();
      hl = (i == 0) ? 16'hFFFF : r[15:0];
      p = (i == 0) ? 16'h0001 : r[31:16];
      r = rnd();
      fl = r[7:0] & 8'hD7;
      k = 2'(i % 3);
      bus(1'b1, REG_PTR, {16'h0, hl});
      bus(1'b1, REG_PR0, {16'h0, p});
      bus(1'b1, REG_FLG, {24'h0, fl});
      go(k == 2'd0 ? 24'h000009 : {8'h00, k == 2'd1 ? 8'h4A : 8'h42, OP_PFX_ED});
      w = w16(k, hl, p, fl);
      bus(1'b0, REG_PTR, 32'h0);
      `CHK(q, {16'h0, w[23:8]})
      bus(1'b0, REG_FLG, 32'h0);
      `CHK(q, {24'h0, w[7:0]})
      stat(k == 2'd0 ? 4'h3 : 4'h4, k == 2'd0 ? 5'h0B : 5'h0F);
    end
    // Pair increments wrap and leave flags alone
    r = rnd();
    bus(1'b1, REG_IX0, 32'h0000_FFFF);
    bus(1'b1, REG_FLG, {24'h0, r[7:0] & 8'hD7});
    go(24'h0023DD);
    bus(1'b0, REG_IX0, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b0, REG_FLG, 32'h0);
    `CHK(q, {24'h0, r[7:0] & 8'hD7})
    stat(4'h2, 5'h0A);
    // Prefixed pair add into the index register, which now holds zero
    bus(1'b1, REG_PR1, {16'h0, r[31:16]});
    go(24'h0019DD);
    w = w16(2'd0, 16'h0000, r[31:16], r[7:0] & 8'hD7);
    bus(1'b0, REG_IX0, 32'h0);
    `CHK(q, {16'h0, w[23:8]})
    bus(1'b0, REG_FLG, 32'h0);
    `CHK(q, {24'h0, w[7:0]})
    stat(4'h4, 5'h0F);
    bus(1'b1, REG_SP, {16'h0, r[31:16]});
    go(24'h000033);
    bus(1'b0, REG_SP, 32'h0);
    `CHK(q, {16'h0, r[31:16] + 16'h0001})
    stat(4'h1, 5'h04);
    // Unsupported opcode raises the error bit and clears the counts
    go(24'h000000);
    bus(1'b0, REG_STAT, 32'h0);
    `CHK(q, 32'h0000_0006)
    wrap_up();
  end
endmodule
